// file: hw/dcpwm_chan.sv
`timescale 1ns/1ps
module dcpwm_chan (
   input wire logic clk,
   input wire logic rst_b,
   input wire dcpwm_pkg::dcpwm_cfg_t cfg,
   input wire logic tick,
   output dcpwm_pkg::dcpwm_sts_t sts
);
   import dcpwm_pkg::*;

   dcpwm_sts_t st_r;
   dcpwm_sts_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.event_p = 1'b0;
      // Counter moves only on prescaled ticks
      if (tick) begin
         if (st_r.count == cfg.period) begin
            st_nxt.count = CNT_ZERO;
            st_nxt.duty_act = cfg.duty;
            st_nxt.pin = (cfg.duty != CNT_ZERO);
            st_nxt.event_p = 1'b1;
         end else begin
            st_nxt.count = st_r.count + CNT_ONE;
            // Low as the count reaches the duty: high for duty ticks
            if (st_nxt.count == st_r.duty_act) begin
               st_nxt.pin = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.count <= CNT_ZERO;
         st_r.duty_act <= CNT_ZERO;
         st_r.pin <= 1'b0;
         st_r.event_p <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sts = st_r;

endmodule

// file: hw/dcpwm_presc.sv
`timescale 1ns/1ps
module dcpwm_presc (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [dcpwm_pkg::SEL_W-1:0] sel,
   output logic tick
);
   import dcpwm_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } dcpwm_presc_state_t;

   dcpwm_presc_state_t st_r;
   dcpwm_presc_state_t st_nxt;
   logic [DIV_W-1:0] mask;

   // Select 0 gives mask 1 (divide by 2), select 7 divides by 256
   assign mask = DIV_FULL >> (SEL_MAX - sel);
   assign tick = run & ((st_r.cnt & mask) == mask);

   always_comb begin
      st_nxt = st_r;
      // Held at zero while stopped so nothing toggles
      if (!run) begin
         st_nxt.cnt = DIV_ZERO;
      end else begin
         st_nxt.cnt = st_r.cnt + DIV_ONE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.cnt <= DIV_ZERO;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// file: hw/dcpwm_top.sv
// Added by the designer: the register addresses and the APB register port.
package dcpwm_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 10;
   localparam int SEL_W = 3;
   localparam int DIV_W = 8;
   localparam int NCH = 2;
   localparam int HI_W = 8;
   localparam int LO_W = 2;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CH_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CH_STRIDE = 8'h20;
   // Offsets inside a channel window
   localparam logic [ADDR_W-1:0] OFS_PERIOD_HI = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PERIOD_LO = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DUTY_HI = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DUTY_LO = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DUTY_ACT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PIN = 8'h18;

   // Control register: per channel a run bit and a prescale select
   localparam int CTRL_CH_SHIFT = 8;
   localparam int CTRL_RUN_POS = 0;
   localparam int CTRL_SEL_POS = 1;

   // Reset values, then counter and prescaler constants
   localparam logic RST_RUN = 1'b0;
   localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
   localparam logic [HI_W-1:0] RST_HI = 8'hff;
   localparam logic [LO_W-1:0] RST_LO = 2'h3;
   localparam logic [HI_W-1:0] RST_DUTY_HI = 8'h00;
   localparam logic [LO_W-1:0] RST_DUTY_LO = 2'h0;
   localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
   localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
   localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
   localparam logic [DIV_W-1:0] DIV_FULL = 8'hff;
   localparam logic [SEL_W-1:0] SEL_MAX = 3'h7;

   typedef struct packed {
      logic run;
      logic [SEL_W-1:0] sel;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] duty;
   } dcpwm_cfg_t;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] duty_act;
      logic pin;
      logic event_p;
   } dcpwm_sts_t;

   typedef struct packed {
      logic run;
      logic [SEL_W-1:0] sel;
      logic [HI_W-1:0] per_hi;
      logic [LO_W-1:0] per_lo;
      logic [HI_W-1:0] duty_hi;
      logic [LO_W-1:0] duty_lo;
   } dcpwm_chreg_t;

   typedef struct packed {
      dcpwm_chreg_t [NCH-1:0] ch;
      logic [NCH-1:0] irq_sts;
      logic [NCH-1:0] irq_en;
      logic irq;
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
   } dcpwm_top_state_t;

endpackage

`timescale 1ns/1ps
module dcpwm_top (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dcpwm_pkg::ADDR_W-1:0] PADDR,
   input wire logic [dcpwm_pkg::DATA_W-1:0] PWDATA,
   output logic [dcpwm_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   output logic OUTPUT_PIN_FIRST,
   output logic OUTPUT_PIN_SECOND
);
   import dcpwm_pkg::*;

   dcpwm_top_state_t st_r;
   dcpwm_top_state_t st_nxt;
   dcpwm_cfg_t [NCH-1:0] cfg;
   dcpwm_sts_t [NCH-1:0] sts;
   logic [NCH-1:0] tick;
   logic [NCH-1:0] events;

   // Per channel prescaler and counter core
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         assign cfg[g].run = st_r.ch[g].run;
         assign cfg[g].sel = st_r.ch[g].sel;
         // Period and duty assemble from high byte and low part
         assign cfg[g].period = {st_r.ch[g].per_hi, st_r.ch[g].per_lo};
         assign cfg[g].duty = {st_r.ch[g].duty_hi, st_r.ch[g].duty_lo};
         assign events[g] = sts[g].event_p;

         dcpwm_presc u_presc (
            .clk(SYS_CLK),
            .rst_b(RST_B),
            .run(cfg[g].run),
            .sel(cfg[g].sel),
            .tick(tick[g])
         );

         dcpwm_chan u_chan (
            .clk(SYS_CLK),
            .rst_b(RST_B),
            .cfg(cfg[g]),
            .tick(tick[g]),
            .sts(sts[g])
         );
      end
   endgenerate

   logic access;
   logic wr_now;
   logic [ADDR_W-1:0] ch_ofs;
   logic hit;
   logic [NCH-1:0] clr_mask;

   assign access = PSEL & PENABLE;
   // Writes land on the edge that also completes the transfer
   assign wr_now = access & st_r.pready & PWRITE;

   always_comb begin
      st_nxt = st_r;
      hit = 1'b0;
      ch_ofs = OFS_CH_BASE;
      clr_mask = '0;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;

      // First access cycle prepares the answer, the second completes it
      if (access && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = RST_RDATA;
         if (PADDR == OFS_CTRL) begin
            hit = 1'b1;
            for (int c = 0; c < NCH; c++) begin
               st_nxt.prdata[c*CTRL_CH_SHIFT+CTRL_RUN_POS] = st_r.ch[c].run;
               st_nxt.prdata[c*CTRL_CH_SHIFT+CTRL_SEL_POS +: SEL_W] =
                  st_r.ch[c].sel;
            end
         end else if (PADDR == OFS_IRQ_STATUS) begin
            hit = 1'b1;
            st_nxt.prdata[NCH-1:0] = st_r.irq_sts;
         end else if (PADDR == OFS_IRQ_CLEAR) begin
            // Write-only: reads as zero
            hit = 1'b1;
         end else if (PADDR == OFS_IRQ_ENABLE) begin
            hit = 1'b1;
            st_nxt.prdata[NCH-1:0] = st_r.irq_en;
         end else begin
            for (int c = 0; c < NCH; c++) begin
               ch_ofs = PADDR - OFS_CH_BASE - OFS_CH_STRIDE * ADDR_W'(c);
               if (PADDR < OFS_CH_BASE) begin
                  ch_ofs = OFS_CH_STRIDE;
               end
               if (ch_ofs == OFS_PERIOD_HI) begin
                  hit = 1'b1;
                  st_nxt.prdata[HI_W-1:0] = st_r.ch[c].per_hi;
               end else if (ch_ofs == OFS_PERIOD_LO) begin
                  hit = 1'b1;
                  st_nxt.prdata[LO_W-1:0] = st_r.ch[c].per_lo;
               end else if (ch_ofs == OFS_DUTY_HI) begin
                  hit = 1'b1;
                  st_nxt.prdata[HI_W-1:0] = st_r.ch[c].duty_hi;
               end else if (ch_ofs == OFS_DUTY_LO) begin
                  hit = 1'b1;
                  st_nxt.prdata[LO_W-1:0] = st_r.ch[c].duty_lo;
               end else if (ch_ofs == OFS_COUNT) begin
                  hit = 1'b1;
                  st_nxt.prdata[CNT_W-1:0] = sts[c].count;
               end else if (ch_ofs == OFS_DUTY_ACT) begin
                  hit = 1'b1;
                  st_nxt.prdata[CNT_W-1:0] = sts[c].duty_act;
               end else if (ch_ofs == OFS_PIN) begin
                  hit = 1'b1;
                  st_nxt.prdata[0] = sts[c].pin;
               end
            end
         end
         st_nxt.pslverr = ~hit;
         // Writes answer zero so no stale word looks like read data
         if (!hit || PWRITE) begin
            st_nxt.prdata = RST_RDATA;
         end
      end

      if (wr_now) begin
         if (PADDR == OFS_CTRL) begin
            for (int c = 0; c < NCH; c++) begin
               st_nxt.ch[c].run = PWDATA[c*CTRL_CH_SHIFT+CTRL_RUN_POS];
               st_nxt.ch[c].sel =
                  PWDATA[c*CTRL_CH_SHIFT+CTRL_SEL_POS +: SEL_W];
            end
         end else if (PADDR == OFS_IRQ_CLEAR) begin
            clr_mask = PWDATA[NCH-1:0];
         end else if (PADDR == OFS_IRQ_ENABLE) begin
            st_nxt.irq_en = PWDATA[NCH-1:0];
         end else begin
            for (int c = 0; c < NCH; c++) begin
               ch_ofs = PADDR - OFS_CH_BASE - OFS_CH_STRIDE * ADDR_W'(c);
               if (PADDR < OFS_CH_BASE) begin
                  ch_ofs = OFS_CH_STRIDE;
               end
               if (ch_ofs == OFS_PERIOD_HI) begin
                  st_nxt.ch[c].per_hi = PWDATA[HI_W-1:0];
               end else if (ch_ofs == OFS_PERIOD_LO) begin
                  st_nxt.ch[c].per_lo = PWDATA[LO_W-1:0];
               end else if (ch_ofs == OFS_DUTY_HI) begin
                  // Only the buffer moves; the active latch waits
                  st_nxt.ch[c].duty_hi = PWDATA[HI_W-1:0];
               end else if (ch_ofs == OFS_DUTY_LO) begin
                  st_nxt.ch[c].duty_lo = PWDATA[LO_W-1:0];
               end
               // Count, active duty and pin words ignore writes
            end
         end
      end

      // A period event in the clearing cycle survives the clear
      st_nxt.irq_sts = (st_r.irq_sts & ~clr_mask) | events;
      st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_en);
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int c = 0; c < NCH; c++) begin
            st_r.ch[c].run <= RST_RUN;
            st_r.ch[c].sel <= RST_SEL;
            st_r.ch[c].per_hi <= RST_HI;
            st_r.ch[c].per_lo <= RST_LO;
            st_r.ch[c].duty_hi <= RST_DUTY_HI;
            st_r.ch[c].duty_lo <= RST_DUTY_LO;
         end
         st_r.irq_sts <= '0;
         st_r.irq_en <= '0;
         st_r.irq <= 1'b0;
         st_r.pready <= 1'b0;
         st_r.pslverr <= 1'b0;
         st_r.prdata <= RST_RDATA;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign PRDATA = st_r.prdata;
   assign PREADY = st_r.pready;
   assign PSLVERR = st_r.pslverr;
   assign IRQ = st_r.irq;
   // Pins come from the channel cores' output flops
   assign OUTPUT_PIN_FIRST = sts[0].pin;
   assign OUTPUT_PIN_SECOND = sts[1].pin;

endmodule

// file: testbench/dcpwm_props.sv
`timescale 1ns/1ps
module dcpwm_props (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dcpwm_pkg::DATA_W-1:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic IRQ,
   input wire logic OUTPUT_PIN_FIRST,
   input wire logic OUTPUT_PIN_SECOND
);
   import dcpwm_pkg::*;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   ready_time_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
      else $error("ready not on second access cycle");
   err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   err_data_a: assert property (PSLVERR |-> PRDATA == RST_RDATA)
      else $error("read data on error");
   wr_data_a: assert property (PREADY && PWRITE |-> PRDATA == RST_RDATA)
      else $error("read data on write");
   pin_first_a: assert property (
      $changed(OUTPUT_PIN_FIRST) |=> $stable(OUTPUT_PIN_FIRST))
      else $error("first pin faster than a tick");
   pin_second_a: assert property (
      $changed(OUTPUT_PIN_SECOND) |=> $stable(OUTPUT_PIN_SECOND))
      else $error("second pin faster than a tick");
   // Either registering style of the level is accepted
   irq_fall_a: assert property (
      $fell(IRQ) |-> $past(PREADY && PWRITE) || $past(PREADY && PWRITE, 2))
      else $error("interrupt dropped without a write");
   pin_rise_c: cover property ($rose(OUTPUT_PIN_FIRST));
   err_c: cover property (PSLVERR);
   irq_c: cover property ($rose(IRQ));
endmodule

// file: testbench/dcpwm_tb_top.sv
`timescale 1ns/1ps
module dcpwm_tb_top;
   import dcpwm_pkg::*;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [15:0] d;
      logic [15:0] x;
      logic err;
   } dcpwm_row_t;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, pin0, pin1;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, r;
   logic e;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int hi, per, t0, n;
   dcpwm_row_t rows [14] = '{
      '{1'b0, 8'h00, 16'h0, 16'h0, 1'b0},
      '{1'b0, 8'h10, 16'h0, 16'hff, 1'b0},
      '{1'b0, 8'h14, 16'h0, 16'h3, 1'b0},
      '{1'b0, 8'h44, 16'h0, 16'h0, 1'b0},
      '{1'b0, 8'h28, 16'h0, 16'h0, 1'b0},
      '{1'b1, 8'h20, 16'h55, 16'h0, 1'b0},
      '{1'b0, 8'h20, 16'h0, 16'h0, 1'b0},
      '{1'b1, 8'h30, 16'h12, 16'h0, 1'b0},
      '{1'b0, 8'h30, 16'h0, 16'h12, 1'b0},
      '{1'b1, 8'h3c, 16'h7, 16'h0, 1'b0},
      '{1'b0, 8'h3c, 16'h0, 16'h3, 1'b0},
      '{1'b0, 8'h04, 16'h0, 16'h0, 1'b0},
      '{1'b0, 8'h08, 16'h0, 16'h0, 1'b0},
      '{1'b0, 8'h80, 16'h0, 16'h0, 1'b1}
   };
   dcpwm_top dut (
      .SYS_CLK(clk),
      .RST_B(rst_b),
      .PSEL(psel),
      .PENABLE(penable),
      .PWRITE(pwrite),
      .PADDR(paddr),
      .PWDATA(pwdata),
      .PRDATA(prdata),
      .PREADY(pready),
      .PSLVERR(pslverr),
      .IRQ(irq),
      .OUTPUT_PIN_FIRST(pin0),
      .OUTPUT_PIN_SECOND(pin1)
   );
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic test_done;
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic f);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // The slave sets the pace; the count only guards a hang
      while (pready !== 1'b1 && k < 50) begin
         k++;
         @(posedge clk);
      end
      q = prdata;
      f = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic f;
      apb(1'b1, a, d, q, f);
   endtask
   task automatic rd(input logic [7:0] a);
      logic f;
      apb(1'b0, a, 32'h0, r, f);
   endtask
   task automatic lvl(input logic c, input logic v);
      int k;
      k = 0;
      @(posedge clk);
      while ((c ? pin1 : pin0) !== v && k < 4000) begin
         k++;
         @(posedge clk);
      end
   endtask
   // The first period after a reprogram is skipped: prescaler phase
   task automatic meas(input logic c);
      lvl(c, 1'b0);
      lvl(c, 1'b1);
      lvl(c, 1'b0);
      lvl(c, 1'b1);
      t0 = cyc;
      lvl(c, 1'b0);
      hi = cyc - t0;
      lvl(c, 1'b1);
      per = cyc - t0;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      test_done();
   end
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("pins", 32'h0, {30'h0, pin1, pin0});
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, {16'h0, rows[i].d}, r, e);
         chk("rdata", {16'h0, rows[i].x}, r);
         chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
      end
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h3);
      wr(8'h1c, 32'h1);
      wr(8'h30, 32'h1);
      wr(8'h34, 32'h1);
      wr(8'h0c, 32'h1);
      wr(8'h00, 32'h1);
      meas(1'b0);
      chk("hi0", 32'h2, hi);
      chk("per0", 32'h8, per);
      rd(8'h04);
      chk("status", 32'h1, r);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h0c, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h0);
      rd(8'h20);
      t0 = r;
      repeat (20) @(posedge clk);
      rd(8'h20);
      chk("count", t0, r);
      wr(8'h08, 32'h3);
      rd(8'h04);
      chk("cleared", 32'h0, r);
      // Channel 1 keeps duty 3 from the table, period is 5
      for (int s = 0; s < 8; s++) begin
         wr(8'h00, 32'h101 | (s << 9));
         meas(1'b1);
         chk("hi1", 32'h3 << (s + 1), hi);
         chk("per1", 32'h6 << (s + 1), per);
      end
      // Period 7 so that the later duty of 5 ends inside the period
      wr(8'h10, 32'h1);
      wr(8'h14, 32'h7);
      wr(8'h1c, 32'h2);
      wr(8'h00, 32'h7);
      lvl(1'b0, 1'b0);
      lvl(1'b0, 1'b1);
      t0 = cyc;
      wr(8'h18, 32'h1);
      wr(8'h1c, 32'h1);
      rd(8'h24);
      chk("dact", 32'h2, r);
      lvl(1'b0, 1'b0);
      chk("hi old", 32'h20, cyc - t0);
      meas(1'b0);
      chk("hi new", 32'h50, hi);
      wr(8'h18, 32'h0);
      wr(8'h1c, 32'h0);
      repeat (256) @(posedge clk);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         if (pin0 !== 1'b0) n++;
      end
      chk("zero duty", 32'h0, n);
      wr(8'h0c, 32'h3);
      wr(8'h00, 32'h101);
      repeat (30) @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      chk("in reset", 32'h0, {29'h0, irq, pin1, pin0});
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h00);
      chk("ctrl", 32'h0, r);
      rd(8'h30);
      chk("per hi", 32'hff, r);
      test_done();
   end
endmodule
bind dcpwm_top dcpwm_props props_i (
   .SYS_CLK(SYS_CLK),
   .RST_B(RST_B),
   .PSEL(PSEL),
   .PENABLE(PENABLE),
   .PWRITE(PWRITE),
   .PRDATA(PRDATA),
   .PREADY(PREADY),
   .PSLVERR(PSLVERR),
   .IRQ(IRQ),
   .OUTPUT_PIN_FIRST(OUTPUT_PIN_FIRST),
   .OUTPUT_PIN_SECOND(OUTPUT_PIN_SECOND)
);
